// ---- bench/iem_expander_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module iem_expander_model #(
    parameter logic [7:0] RD_VAL = 8'h5a
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [15:0] lim_i,
    output logic sda_oe_o
);
    logic [7:0] sh_reg = 8'h00;
    logic [7:0] log_q[$];
    int bit_n = 0;
    logic first = 1'b0;
    logic rd_req = 1'b0;
    logic tx = 1'b0;

    initial sda_oe_o = 1'b0;

    // Start or repeated start restarts byte framing
    always @(negedge sda_i) if (scl_i) begin
        bit_n = 0;
        first = 1'b1;
        tx = 1'b0;
    end

    always @(posedge scl_i) begin
        if (bit_n < 8) begin
            sh_reg = {sh_reg[6:0], sda_i};
            bit_n++;
            if (bit_n == 8 && !tx) begin
                log_q.push_back(sh_reg);
                rd_req = first & sh_reg[0];
                first = 1'b0;
            end
        end else begin
            bit_n = 0;
            tx = rd_req;
            rd_req = 1'b0;
        end
    end

    // Beyond the byte limit the model refuses, so a scenario can cut a long sequence short
    always @(negedge scl_i) begin
        if (bit_n == 8 && !tx) sda_oe_o = (log_q.size() <= lim_i);
        else if (tx && bit_n < 8) sda_oe_o = ~RD_VAL[7 - bit_n];
        else sda_oe_o = 1'b0;
    end
endmodule

`default_nettype wire

// ---- bench/iem_io_expander_manager_checker.sv ----
`timescale 1ns/100ps
`default_nettype none

module iem_io_expander_manager_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic eeprom_done_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_no_early_run: assert property (!busy_o && !eeprom_done_i |=> !busy_o)
        else $error("sequence started before load done");
    a_busy_cause: assert property ($rose(busy_o) |-> $past(eeprom_done_i))
        else $error("busy rose without load done");
    a_start_busy: assert property ($rose(sda_oe_o) && !scl_oe_o |-> busy_o)
        else $error("start condition while idle");
    a_open_drain: assert property (!scl_o && !sda_o)
        else $error("pin output level not low");
    a_quarter_hold: assert property ($changed(scl_oe_o) |=> $stable(scl_oe_o)[*8])
        else $error("clock phase too short");
    a_idle_release: assert property ($fell(busy_o) |=> !scl_oe_o && !sda_oe_o)
        else $error("bus not released after sequence");
endmodule

`default_nettype wire

// ---- bench/iem_io_expander_manager_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module iem_io_expander_manager_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, eeprom_done_i = 1'b0;
    logic [15:0] port_active_i = 16'hfffb, link_up_i = 16'h0f00, link_act_i = 16'h0300;
    logic [15:0] lim = 16'hffff;
    logic [31:0] wb_dat_o, d;
    logic wb_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, busy_o, m_oe;
    wire logic scl_w = ~scl_oe_o;
    wire logic sda_w = ~(sda_oe_o | m_oe);
    int failures = 0, n_tests = 0, cyc_n = 0;
    logic [7:0] exp_q[$];

    iem_io_expander_manager i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .eeprom_done_i(eeprom_done_i), .port_active_i(port_active_i), .link_up_i(link_up_i),
        .link_act_i(link_act_i), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o));
    iem_expander_model i_exp (.scl_i(scl_w), .sda_i(sda_w), .lim_i(lim), .sda_oe_o(m_oe));

    initial forever #20 clk_i = ~clk_i;

    task automatic test_done;
        if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Whole run is about 106k cycles, mostly the one full hot-plug sequence
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 120000) begin
            failures++;
            test_done;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb_go(input logic [7:0] a, input logic [31:0] w, input logic [3:0] s,
                         input logic we);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= a;
        wb_dat_i <= w;
        wb_sel_i <= s;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        d = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask

    task automatic ew(input logic [6:0] a, input logic [7:0] r, input logic [7:0] v,
                      input logic rd);
        exp_q.push_back({a, 1'b0});
        exp_q.push_back(r);
        exp_q.push_back(rd ? {a, 1'b1} : v);
    endtask

    // One expander sequence; the model's byte log is compared in full
    task automatic run(input logic [7:0] a, input logic [31:0] w, input logic [3:0] s,
                       input logic [15:0] l);
        i_exp.log_q = {};
        lim <= l;
        wb_go(a, w, s, 1'b1);
        if (eeprom_done_i !== 1'b1) begin
            repeat (300) @(posedge clk_i);
            chk(busy_o, 1'b0);
            eeprom_done_i <= 1'b1;
        end
        while (busy_o !== 1'b1) @(posedge clk_i);
        while (busy_o !== 1'b0) @(posedge clk_i);
        chk(i_exp.log_q.size(), exp_q.size());
        foreach (exp_q[i]) chk(i_exp.log_q[i], exp_q[i]);
        exp_q = {};
    endtask

    // Expander 0: port 0 attention on, port 2 inactive
    task automatic t_hotplug;
        wb_go(8'h18, 32'h0000_fffe, 4'hf, 1'b1);
        ew(7'h20, 8'h02, 8'hfc, 1'b0);
        ew(7'h20, 8'h03, 8'hfb, 1'b0);
        ew(7'h20, 8'h04, 8'h00, 1'b0);
        ew(7'h20, 8'h05, 8'h00, 1'b0);
        ew(7'h20, 8'h06, 8'hf8, 1'b0);
        ew(7'h20, 8'h07, 8'hf8, 1'b0);
        ew(7'h20, 8'h00, 8'h00, 1'b1);
        ew(7'h20, 8'h01, 8'h00, 1'b1);
        run(8'h00, 32'h0000_0020, 4'h1, 16'hffff);
        wb_go(8'h14, 32'h0, 4'hf, 1'b0);
        chk(d, 32'h0000_5a5a);
    endtask

    // Expander 13 refused after its link bytes; fields 14 and 15 ignored
    task automatic t_link_nack;
        ew(7'h2d, 8'h02, 8'hf0, 1'b0);
        ew(7'h2d, 8'h03, 8'hfc, 1'b0);
        exp_q.push_back(8'h5a);
        run(8'h0c, 32'hffff_ad00, 4'he, 16'h0006);
        wb_go(8'h0c, 32'h0, 4'hf, 1'b0);
        chk(d, 32'h0000_2d00);
        wb_go(8'h10, 32'h0, 4'hf, 1'b0);
        chk(d[17], 1'b1);
        wb_go(8'h10, 32'h0002_0000, 4'h4, 1'b1);
        wb_go(8'h10, 32'h0, 4'hf, 1'b0);
        chk(d[17], 1'b0);
    endtask

    // Expander 8 all inputs, cut short after the first direction byte
    task automatic t_inputs;
        ew(7'h28, 8'h04, 8'h00, 1'b0);
        ew(7'h28, 8'h05, 8'h00, 1'b0);
        ew(7'h28, 8'h06, 8'hff, 1'b0);
        exp_q.push_back(8'h50);
        run(8'h08, 32'h0000_0028, 4'h1, 16'h0009);
        wb_go(8'h20, 32'h0, 4'hf, 1'b0);
        chk(d, 32'h0);
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_hotplug;
        t_link_nack;
        t_inputs;
        test_done;
    end
endmodule

bind iem_io_expander_manager iem_io_expander_manager_checker i_chk (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .eeprom_done_i, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o,
    .busy_o);

`default_nettype wire

// ---- verilog/iem_i2c_bit_engine.sv ----
`timescale 1ns/100ps
`default_nettype none

module iem_i2c_bit_engine
    import iem_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire iem_i2c_cmd_t cmd_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o,
    output logic done_o,
    output logic nack_o,
    output logic [7:0] rx_o
);
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [7:0] div_reg;
    logic busy_reg;
    iem_i2c_op_t op_reg;
    logic [1:0] q_reg;
    logic [3:0] bit_reg;
    logic [8:0] tx_reg;
    logic [8:0] rx_reg;

    wire tick = div_reg == QUARTER_CYC - 8'h01;
    wire is_bit = (op_reg == OP_WRITE) || (op_reg == OP_READ);
    wire last_bit = bit_reg == 4'h8;
    wire finish = !is_bit || last_bit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            div_reg <= 8'h00;
            busy_reg <= 1'b0;
            op_reg <= OP_START;
            q_reg <= 2'h0;
            bit_reg <= 4'h0;
            tx_reg <= 9'h1ff;
            rx_reg <= 9'h000;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            done_o <= 1'b0;
            nack_o <= 1'b0;
            rx_o <= 8'h00;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            done_o <= 1'b0;
            div_reg <= (tick || !busy_reg) ? 8'h00 : div_reg + 8'h01;
            if (!busy_reg && go_i) begin
                busy_reg <= 1'b1;
                op_reg <= cmd_i.op;
                q_reg <= 2'h0;
                bit_reg <= 4'h0;
                // Reads always end with a NACK: one byte per read
                tx_reg <= (cmd_i.op == OP_WRITE) ? {cmd_i.data, 1'b1} : 9'h1ff;
            end else if (busy_reg && tick) begin
                case (q_reg)
                    2'h0: begin
                        sda_oe_o <= is_bit ? ~tx_reg[8] : (op_reg == OP_STOP);
                        q_reg <= 2'h1;
                    end
                    2'h1: begin
                        scl_oe_o <= 1'b0;
                        q_reg <= 2'h2;
                    end
                    2'h2: begin
                        // Holds here while the far end stretches the clock
                        if (scl_sync_reg[1]) begin
                            rx_reg <= {rx_reg[7:0], sda_sync_reg[1]};
                            if (op_reg == OP_START) begin
                                sda_oe_o <= 1'b1;
                            end
                            q_reg <= 2'h3;
                        end
                    end
                    default: begin
                        if (op_reg == OP_STOP) begin
                            sda_oe_o <= 1'b0;
                        end else begin
                            scl_oe_o <= 1'b1;
                        end
                        q_reg <= 2'h0;
                        tx_reg <= {tx_reg[7:0], 1'b1};
                        bit_reg <= bit_reg + 4'h1;
                        if (finish) begin
                            busy_reg <= 1'b0;
                            done_o <= 1'b1;
                            rx_o <= rx_reg[8:1];
                            nack_o <= (op_reg == OP_WRITE) && rx_reg[0];
                        end
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// ---- verilog/iem_io_expander_manager.sv ----
`timescale 1ns/100ps
`default_nettype none

module iem_io_expander_manager
    import iem_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic eeprom_done_i,
    input wire logic [15:0] port_active_i,
    input wire logic [15:0] link_up_i,
    input wire logic [15:0] link_act_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic busy_o
);
    typedef enum logic [3:0] {
        S_IDLE,
        S_START,
        S_ADDRW,
        S_REG,
        S_DATA,
        S_RSTART,
        S_ADDRR,
        S_RDATA,
        S_STOP
    } iem_state_t;

    logic [6:0] exp_addr_reg [NUM_EXP];
    logic [13:0] pending_reg;
    logic [13:0] pending_next;
    iem_state_t state_reg;
    iem_state_t state_next;
    logic [3:0] cur_reg;
    logic [3:0] cur_next;
    logic [2:0] step_reg;
    logic [2:0] step_next;
    logic abort_reg;
    logic abort_next;
    logic go_reg;
    logic go_next;
    iem_i2c_cmd_t cmd_reg;
    iem_i2c_cmd_t cmd_next;
    logic nack_err_reg;
    logic [15:0] indata_reg;
    logic [3:0] inidx_reg;
    iem_slot_t slot_reg;
    logic pull_low_reg;
    logic eng_done;
    logic eng_nack;
    logic [7:0] eng_rx;
    logic eng_scl_oe;
    logic eng_sda_oe;

    function automatic logic [31:0] merge32(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [7:0] addr_field(input logic [3:0] idx);
        return (32'(idx) < NUM_EXP) ? {1'b0, exp_addr_reg[idx]} : 8'h00;
    endfunction

    // Expander k: lower byte port 4*(k/2)+(k%2), upper byte two above
    function automatic logic [3:0] port_of(input logic [3:0] k, input logic upper);
        return {k[2:1], upper, k[0]};
    endfunction

    // Hot-plug byte: bit0 attention, bit1 power indicator, bit2 power enable, rest inputs
    function automatic logic [7:0] hp_byte(input logic [3:0] p);
        logic act;
        act = port_active_i[p];
        return {5'h1f,
                act ? slot_reg.pwr_en[p] : 1'b0,
                act ? slot_reg.pwr_ind[p] : 1'b1,
                act ? slot_reg.attn[p] : 1'b1};
    endfunction

    function automatic logic has_outputs(input logic [3:0] k);
        return !((k == EXP_MRL) || (k == EXP_FRST));
    endfunction

    function automatic logic [3:0] lowest_set(input logic [13:0] v);
        logic [3:0] res;
        res = 4'h0;
        for (int i = NUM_EXP - 1; i >= 0; i--) begin
            if (v[i]) begin
                res = 4'(i);
            end
        end
        return res;
    endfunction

    // Wishbone decode
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire [7:0] wb_word = {wb_adr_i[7:2], 2'b00};
    wire hit_addr = wb_word < STATUS_OFS;
    wire hit_status = wb_word == STATUS_OFS;
    wire hit_indata = wb_word == INDATA_OFS;
    wire hit_slot0 = wb_word == SLOT0_OFS;
    wire hit_slot1 = wb_word == SLOT1_OFS;

    wire [13:0] set_pend;
    genvar gi;
    for (gi = 0; gi < NUM_EXP; gi++) begin : g_field
        // One byte lane per field; any written lane starts that expander
        assign set_pend[gi] = wb_wr && hit_addr && (wb_adr_i[3:2] == 2'(gi / 4))
                              && wb_sel_i[gi % 4];
    end

    wire [31:0] rd_addr_word = {addr_field({wb_adr_i[3:2], 2'h3}),
                                addr_field({wb_adr_i[3:2], 2'h2}),
                                addr_field({wb_adr_i[3:2], 2'h1}),
                                addr_field({wb_adr_i[3:2], 2'h0})};
    wire [31:0] rd_status = {13'h0000, eeprom_done_i, nack_err_reg, busy_o, 2'h0, pending_reg};
    wire [31:0] rd_indata = {12'h000, inidx_reg, indata_reg};
    wire [31:0] rd_slot0 = {slot_reg.pwr_ind, slot_reg.attn};
    wire [31:0] rd_slot1 = {slot_reg.ilock, slot_reg.pwr_en};
    wire [31:0] rd_data = hit_addr ? rd_addr_word :
                          hit_status ? rd_status :
                          hit_indata ? rd_indata :
                          hit_slot0 ? rd_slot0 :
                          hit_slot1 ? rd_slot1 : 32'h0000_0000;

    // Bytes sent to the current expander
    wire [15:0] ilock_act = slot_reg.ilock & port_active_i;
    wire [15:0] link_up_n = ~(link_up_i & port_active_i);
    wire [15:0] link_act_n = ~(link_act_i & port_active_i);
    wire is_hp = cur_reg < EXP_MRL;
    wire [7:0] lo_out = is_hp ? hp_byte(port_of(cur_reg, 1'b0)) :
                        (cur_reg == EXP_ILOCK_LO) ? ilock_act[7:0] :
                        (cur_reg == EXP_ILOCK_HI) ? ilock_act[15:8] :
                        (cur_reg == EXP_LINK_LO) ? link_up_n[7:0] :
                        link_up_n[15:8];
    wire [7:0] hi_out = is_hp ? hp_byte(port_of(cur_reg, 1'b1)) :
                        (cur_reg == EXP_ILOCK_LO) ? ilock_act[7:0] :
                        (cur_reg == EXP_ILOCK_HI) ? ilock_act[15:8] :
                        (cur_reg == EXP_LINK_LO) ? link_act_n[7:0] :
                        link_act_n[15:8];
    wire [7:0] dir_byte = is_hp ? HP_DIR :
                          has_outputs(cur_reg) ? DIR_ALL_OUT : DIR_ALL_IN;
    wire [7:0] data_byte = (step_reg == 3'h0) ? lo_out :
                           (step_reg == 3'h1) ? hi_out :
                           (step_reg == 3'h2) ? NO_INVERT :
                           (step_reg == 3'h3) ? NO_INVERT :
                           dir_byte;
    wire is_read_step = step_reg[2] && step_reg[1];
    wire [7:0] reg_index = is_read_step ? {7'h00, step_reg[0]} :
                           XREG_OUT0 + {5'h00, step_reg};
    wire [7:0] addr_w = {exp_addr_reg[cur_reg], 1'b0};
    wire [7:0] addr_r = {exp_addr_reg[cur_reg], 1'b1};

    wire [3:0] first = lowest_set(pending_reg);
    wire launch = (state_reg == S_IDLE) && eeprom_done_i && (|pending_reg);
    wire [13:0] first_hot = 14'h0001 << first;

    // A request arriving as its expander is launched is kept for a rerun
    assign pending_next = (pending_reg & ~(launch ? first_hot : 14'h0000)) | set_pend;

    always_comb begin
        state_next = state_reg;
        cur_next = cur_reg;
        step_next = step_reg;
        abort_next = abort_reg;
        cmd_next = cmd_reg;
        go_next = 1'b0;
        if (launch) begin
            state_next = S_START;
            cur_next = first;
            step_next = has_outputs(first) ? STEP_OUT0 : STEP_CFG0;
            abort_next = 1'b0;
            cmd_next = '{op: OP_START, data: 8'h00};
            go_next = 1'b1;
        end else if (eng_done && state_reg != S_IDLE) begin
            go_next = 1'b1;
            if (eng_nack) begin
                // A missing expander ends its sequence with a stop
                state_next = S_STOP;
                abort_next = 1'b1;
                cmd_next = '{op: OP_STOP, data: 8'h00};
            end else begin
                case (state_reg)
                    S_START: begin
                        state_next = S_ADDRW;
                        cmd_next = '{op: OP_WRITE, data: addr_w};
                    end
                    S_ADDRW: begin
                        state_next = S_REG;
                        cmd_next = '{op: OP_WRITE, data: reg_index};
                    end
                    S_REG: begin
                        if (is_read_step) begin
                            state_next = S_RSTART;
                            cmd_next = '{op: OP_START, data: 8'h00};
                        end else begin
                            state_next = S_DATA;
                            cmd_next = '{op: OP_WRITE, data: data_byte};
                        end
                    end
                    S_RSTART: begin
                        state_next = S_ADDRR;
                        cmd_next = '{op: OP_WRITE, data: addr_r};
                    end
                    S_ADDRR: begin
                        state_next = S_RDATA;
                        cmd_next = '{op: OP_READ, data: 8'h00};
                    end
                    S_DATA, S_RDATA: begin
                        state_next = S_STOP;
                        cmd_next = '{op: OP_STOP, data: 8'h00};
                    end
                    S_STOP: begin
                        if (abort_reg || step_reg == STEP_LAST) begin
                            state_next = S_IDLE;
                            go_next = 1'b0;
                        end else begin
                            state_next = S_START;
                            step_next = step_reg + 3'h1;
                            cmd_next = '{op: OP_START, data: 8'h00};
                        end
                    end
                    default: begin
                        state_next = S_IDLE;
                        go_next = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= S_IDLE;
            cur_reg <= 4'h0;
            step_reg <= 3'h0;
            abort_reg <= 1'b0;
            go_reg <= 1'b0;
            cmd_reg <= '{op: OP_START, data: 8'h00};
            pending_reg <= 14'h0000;
            busy_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            step_reg <= step_next;
            abort_reg <= abort_next;
            go_reg <= go_next;
            cmd_reg <= cmd_next;
            pending_reg <= pending_next;
            busy_o <= state_next != S_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_EXP; i++) begin
                exp_addr_reg[i] <= 7'h00;
            end
        end else begin
            for (int i = 0; i < NUM_EXP; i++) begin
                if (set_pend[i]) begin
                    exp_addr_reg[i] <= wb_dat_i[8*(i%4) +: 7];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_reg <= SLOT_RESET;
        end else if (wb_wr && hit_slot0) begin
            {slot_reg.pwr_ind, slot_reg.attn} <= merge32(rd_slot0, wb_dat_i, wb_sel_i);
        end else if (wb_wr && hit_slot1) begin
            {slot_reg.ilock, slot_reg.pwr_en} <= merge32(rd_slot1, wb_dat_i, wb_sel_i);
        end
    end

    wire nack_clr = wb_wr && hit_status && wb_sel_i[2] && wb_dat_i[ST_NACK_BIT];
    wire nack_set = eng_done && eng_nack && (state_reg != S_IDLE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nack_err_reg <= 1'b0;
            indata_reg <= 16'h0000;
            inidx_reg <= 4'h0;
        end else begin
            // Set wins over a same-cycle clear
            nack_err_reg <= nack_set || (nack_err_reg && !nack_clr);
            if (eng_done && state_reg == S_RDATA) begin
                inidx_reg <= cur_reg;
                if (step_reg[0]) begin
                    indata_reg[15:8] <= eng_rx;
                end else begin
                    indata_reg[7:0] <= eng_rx;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            pull_low_reg <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            pull_low_reg <= 1'b0;
            if (wb_req) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    iem_i2c_bit_engine u_engine (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .go_i(go_reg),
        .cmd_i(cmd_reg),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_oe_o(eng_scl_oe),
        .sda_oe_o(eng_sda_oe),
        .done_o(eng_done),
        .nack_o(eng_nack),
        .rx_o(eng_rx)
    );

    // Open drain: level is always low, only the enables move
    assign scl_o = pull_low_reg;
    assign sda_o = pull_low_reg;
    assign scl_oe_o = eng_scl_oe;
    assign sda_oe_o = eng_sda_oe;
endmodule

`default_nettype wire

// ---- verilog/iem_pkg.sv ----
`default_nettype none

package iem_pkg;
    localparam int NUM_EXP = 14;
    localparam int NUM_PORT = 16;

    localparam logic [7:0] ADDR0_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] INDATA_OFS = 8'h14;
    localparam logic [7:0] SLOT0_OFS = 8'h18;
    localparam logic [7:0] SLOT1_OFS = 8'h1c;
    localparam int ST_NACK_BIT = 17;

    localparam logic [3:0] EXP_MRL = 4'h8;
    localparam logic [3:0] EXP_ILOCK_LO = 4'h9;
    localparam logic [3:0] EXP_ILOCK_HI = 4'ha;
    localparam logic [3:0] EXP_FRST = 4'hb;
    localparam logic [3:0] EXP_LINK_LO = 4'hc;
    localparam logic [3:0] EXP_LINK_HI = 4'hd;

    localparam logic [7:0] XREG_OUT0 = 8'h02;
    localparam logic [7:0] NO_INVERT = 8'h00;
    localparam logic [7:0] HP_DIR = 8'hf8;
    localparam logic [7:0] DIR_ALL_IN = 8'hff;
    localparam logic [7:0] DIR_ALL_OUT = 8'h00;

    localparam logic [2:0] STEP_OUT0 = 3'h0;
    localparam logic [2:0] STEP_CFG0 = 3'h2;
    localparam logic [2:0] STEP_LAST = 3'h7;

    localparam int I2C_QUARTER_NS = 2500;
    localparam int CLK_MHZ = 25;
    localparam logic [7:0] QUARTER_CYC = 8'((I2C_QUARTER_NS * CLK_MHZ + 999) / 1000);

    typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} iem_i2c_op_t;

    typedef struct packed {
        iem_i2c_op_t op;
        logic [7:0] data;
    } iem_i2c_cmd_t;

    typedef struct packed {
        logic [15:0] attn;
        logic [15:0] pwr_ind;
        logic [15:0] pwr_en;
        logic [15:0] ilock;
    } iem_slot_t;

    localparam iem_slot_t SLOT_RESET = '{
        attn: 16'hffff, pwr_ind: 16'h0000, pwr_en: 16'hffff, ilock: 16'h0000};
endpackage

`default_nettype wire
